// [hw/adcsq_pkg.sv]
// ****************************************************************
// Register map, field layout and constants of the sequence control.
// ****************************************************************
package adcsq_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register byte addresses.
    localparam logic [7:0] OFF_MISC_CONTROL     = 8'h63;
    localparam logic [7:0] OFF_TIMING_CONTROL   = 8'h64;
    localparam logic [7:0] OFF_SEQUENCE_CONTROL = 8'h65;
    localparam logic [7:0] OFF_STATUS_SEQUENCE  = 8'h66;
    localparam logic [7:0] OFF_STATUS_CONVERT   = 8'h67;
    localparam logic [7:0] OFF_RESULT_BASE      = 8'h70;
    localparam logic [7:0] OFF_IRQ_STATUS       = 8'h78;
    localparam logic [7:0] OFF_IRQ_MASK         = 8'h79;

    // Field positions.
    localparam int SEQ_EIGHT_BIT    = 6;
    localparam int SEQ_SCAN_BIT     = 5;
    localparam int SEQ_MULTI_BIT    = 4;
    localparam int SEQ_SPECIAL_BIT  = 3;
    localparam int MISC_ONE_BIT     = 3;
    localparam int MISC_FIFO_BIT    = 2;
    localparam int TIM_RES10_BIT    = 7;
    localparam int STAT_SEQDONE_BIT = 7;
    localparam int IRQ_SEQ_BIT      = 0;
    localparam int IRQ_CONV_BIT     = 1;
    localparam int IRQ_SELFTEST_BIT = 2;

    // Reset values.
    localparam logic [6:0] RST_SEQUENCE_CONTROL = 7'h00;
    localparam logic [3:0] RST_MISC_CONTROL     = 4'h0;
    localparam logic [7:0] RST_TIMING_CONTROL   = 8'h01;
    localparam logic [2:0] RST_IRQ              = 3'h0;

    // Sequence lengths.
    localparam logic [3:0] LEN_ONE   = 4'h1;
    localparam logic [3:0] LEN_FOUR  = 4'h4;
    localparam logic [3:0] LEN_EIGHT = 4'h8;

    // Internal source codes and their expected 8-bit results.
    localparam logic [2:0] SRC_HIGH_REF = 3'h4;
    localparam logic [2:0] SRC_LOW_REF  = 3'h5;
    localparam logic [2:0] SRC_MID_REF  = 3'h6;
    localparam logic [7:0] CODE_HIGH    = 8'hFF;
    localparam logic [7:0] CODE_LOW     = 8'h00;
    localparam logic [7:0] CODE_MID     = 8'h7F;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_CONVERT} adcsq_state_t;

endpackage

// [hw/adcsq_source_decode.sv]
`timescale 1ns/1ps

// ****************************************************************
// Analog source decode for the converter input multiplexer.
// ****************************************************************
module adcsq_source_decode (
    // Selected source.
    input  wire logic       i_special,
    input  wire logic [2:0] i_code,
    // Multiplexer selects.
    output logic [7:0]      o_input_select,
    output logic            o_ref_high,
    output logic            o_ref_low,
    output logic            o_ref_mid,
    // Self-test expectation.
    output logic            o_expect_valid,
    output logic [7:0]      o_expect_code
);

    // External inputs map the code straight onto the input number.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_input
            assign o_input_select[g] = !i_special && (i_code == 3'(g));
        end
    endgenerate

    // Special codes with a clear top bit and special code seven select nothing at all.
    assign o_ref_high     = i_special && (i_code == adcsq_pkg::SRC_HIGH_REF);
    assign o_ref_low      = i_special && (i_code == adcsq_pkg::SRC_LOW_REF);
    assign o_ref_mid      = i_special && (i_code == adcsq_pkg::SRC_MID_REF);
    assign o_expect_valid = o_ref_high || o_ref_low || o_ref_mid;
    assign o_expect_code  = o_ref_high ? adcsq_pkg::CODE_HIGH :
                            o_ref_low  ? adcsq_pkg::CODE_LOW  : adcsq_pkg::CODE_MID;

endmodule

// [hw/adcsq_control.sv]
`timescale 1ns/1ps

module adcsq_control (
    // Clock and reset.
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    // Register port.
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    // Converter core.
    output logic            o_conv_start,
    output logic            o_conv_abort,
    output logic [2:0]      o_conv_channel,
    output logic            o_conv_special,
    output logic [7:0]      o_input_select,
    output logic            o_ref_high,
    output logic            o_ref_low,
    output logic            o_ref_mid,
    output logic [7:0]      o_timing_control,
    input  wire logic       i_conv_done,
    input  wire logic [7:0] i_conv_result,
    // Interrupt.
    output logic            o_irq
);

    // ****************************************************************
    // Registers and state.
    // ****************************************************************
    logic [6:0]               seq_ctl;
    logic [3:0]               misc_ctl;
    logic [7:0]               timing_ctl;
    logic [2:0]               irq_status;
    logic [2:0]               irq_mask;
    logic                     seq_done;
    logic [7:0]               conv_done;
    logic [2:0]               conv_idx;
    logic [2:0]               res_idx;
    logic [7:0]               results [0:7];
    adcsq_pkg::adcsq_state_t  state;
    adcsq_pkg::adcsq_state_t  next_state;

    // ****************************************************************
    // Decode.
    // ****************************************************************
    wire        wr_seq    = i_wr && (i_addr == adcsq_pkg::OFF_SEQUENCE_CONTROL);
    wire        wr_tim    = i_wr && (i_addr == adcsq_pkg::OFF_TIMING_CONTROL);
    wire        wr_misc   = i_wr && (i_addr == adcsq_pkg::OFF_MISC_CONTROL);
    wire        wr_mask   = i_wr && (i_addr == adcsq_pkg::OFF_IRQ_MASK);
    wire        rd_irq    = i_rd && (i_addr == adcsq_pkg::OFF_IRQ_STATUS);
    wire        rd_result = i_addr[7:3] == adcsq_pkg::OFF_RESULT_BASE[7:3];
    wire        start_req = wr_seq || wr_tim;
    wire        eight_sel = seq_ctl[adcsq_pkg::SEQ_EIGHT_BIT];
    wire        one_sel   = misc_ctl[adcsq_pkg::MISC_ONE_BIT];
    wire        scan_mode = seq_ctl[adcsq_pkg::SEQ_SCAN_BIT];
    wire        multi     = seq_ctl[adcsq_pkg::SEQ_MULTI_BIT];
    wire        special   = seq_ctl[adcsq_pkg::SEQ_SPECIAL_BIT];
    wire        fifo_mode = misc_ctl[adcsq_pkg::MISC_FIFO_BIT];
    wire [2:0]  base_code = seq_ctl[2:0];
    wire        res10     = timing_ctl[adcsq_pkg::TIM_RES10_BIT];

    // Eight-select wins over one-select.
    wire [3:0]  seq_len   = eight_sel ? adcsq_pkg::LEN_EIGHT :
                            one_sel   ? adcsq_pkg::LEN_ONE   : adcsq_pkg::LEN_FOUR;
    wire        last_conv = {1'b0, conv_idx} == 4'(seq_len - 4'h1);

    // The 3-bit sum wraps from seven back to zero by itself.
    wire [2:0]  next_chan = multi ? 3'(base_code + conv_idx) : base_code;

    // A result arriving with a restart belongs to the aborted run and is dropped.
    wire        done_ev   = (state == adcsq_pkg::ST_CONVERT) && i_conv_done
                            && !o_conv_start && !start_req;
    wire        seq_end   = done_ev && last_conv;

    wire        expect_valid;
    wire [7:0]  expect_code;
    wire        mismatch  = done_ev && o_conv_special && expect_valid && !res10
                            && (i_conv_result != expect_code);

    // ****************************************************************
    // Sequencer.
    // ****************************************************************
    // Next state of the conversion sequencer.
    always_comb begin
        next_state = state;
        unique case (state)
            adcsq_pkg::ST_IDLE: begin
                next_state = adcsq_pkg::ST_IDLE;
            end
            adcsq_pkg::ST_SETUP: begin
                next_state = adcsq_pkg::ST_CONVERT;
            end
            adcsq_pkg::ST_CONVERT: begin
                if (seq_end) begin
                    next_state = scan_mode ? adcsq_pkg::ST_SETUP : adcsq_pkg::ST_IDLE;
                end else if (done_ev) begin
                    next_state = adcsq_pkg::ST_SETUP;
                end
            end
        endcase
        if (start_req) begin
            next_state = adcsq_pkg::ST_SETUP;
        end
    end

    // State and the conversion position within the sequence.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state    <= adcsq_pkg::ST_IDLE;
            conv_idx <= 3'h0;
        end else begin
            state <= next_state;
            if (start_req || seq_end) begin
                conv_idx <= 3'h0;
            end else if (done_ev) begin
                conv_idx <= 3'(conv_idx + 3'h1);
            end
        end
    end

    // Channel is latched in setup so it is stable for the whole conversion.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_conv_start   <= 1'b0;
            o_conv_channel <= 3'h0;
            o_conv_special <= 1'b0;
        end else begin
            o_conv_start <= (state == adcsq_pkg::ST_SETUP) && !start_req;
            if (state == adcsq_pkg::ST_SETUP) begin
                o_conv_channel <= next_chan;
                o_conv_special <= special;
            end
        end
    end

    assign o_conv_abort     = start_req && (state != adcsq_pkg::ST_IDLE);
    assign o_timing_control = timing_ctl;

    // Result index: FIFO mode never rewinds it, normal runs restart at zero.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            res_idx <= 3'h0;
        end else if (start_req) begin
            res_idx <= fifo_mode ? res_idx : 3'h0;
        end else if (done_ev) begin
            res_idx <= (!fifo_mode && last_conv) ? 3'h0 : 3'(res_idx + 3'h1);
        end
    end

    // ****************************************************************
    // Results and flags.
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_result
            always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    results[g]   <= 8'h00;
                    conv_done[g] <= 1'b0;
                end else begin
                    if (done_ev && (res_idx == 3'(g))) begin
                        results[g] <= i_conv_result;
                    end
                    if (start_req) begin
                        conv_done[g] <= 1'b0;
                    end else if (done_ev && (res_idx == 3'(g))) begin
                        conv_done[g] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Sequence done flag; only a restart clears it.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seq_done <= 1'b0;
        end else if (start_req) begin
            seq_done <= 1'b0;
        end else if (seq_end) begin
            seq_done <= 1'b1;
        end
    end

    // Source decode for the input multiplexer and self-test expectation.
    adcsq_source_decode u_decode (
        .i_special      (o_conv_special),
        .i_code         (o_conv_channel),
        .o_input_select (o_input_select),
        .o_ref_high     (o_ref_high),
        .o_ref_low      (o_ref_low),
        .o_ref_mid      (o_ref_mid),
        .o_expect_valid (expect_valid),
        .o_expect_code  (expect_code)
    );

    // ****************************************************************
    // Register file and interrupt.
    // ****************************************************************
    // A restart cancels pending sequence and conversion requests; a new event wins.
    wire [2:0] irq_set  = {mismatch, done_ev, seq_end};
    wire [2:0] irq_keep = rd_irq ? 3'h0 : (start_req ? (irq_status & 3'h4) : irq_status);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seq_ctl    <= adcsq_pkg::RST_SEQUENCE_CONTROL;
            misc_ctl   <= adcsq_pkg::RST_MISC_CONTROL;
            timing_ctl <= adcsq_pkg::RST_TIMING_CONTROL;
            irq_mask   <= adcsq_pkg::RST_IRQ;
            irq_status <= adcsq_pkg::RST_IRQ;
        end else begin
            if (wr_seq) begin
                seq_ctl <= i_wdata[6:0];
            end
            if (wr_misc) begin
                misc_ctl <= i_wdata[3:0];
            end
            if (wr_tim) begin
                timing_ctl <= i_wdata;
            end
            if (wr_mask) begin
                irq_mask <= i_wdata[2:0];
            end
            irq_status <= irq_keep | irq_set;
        end
    end

    assign o_irq = |(irq_status & irq_mask);

    // Read selection; unmapped addresses read as zero.
    wire [7:0] rd_value =
        (i_addr == adcsq_pkg::OFF_SEQUENCE_CONTROL) ? {1'b0, seq_ctl} :
        (i_addr == adcsq_pkg::OFF_MISC_CONTROL)     ? {4'h0, misc_ctl} :
        (i_addr == adcsq_pkg::OFF_TIMING_CONTROL)   ? timing_ctl :
        (i_addr == adcsq_pkg::OFF_STATUS_SEQUENCE)  ? {seq_done, 4'h0, res_idx} :
        (i_addr == adcsq_pkg::OFF_STATUS_CONVERT)   ? conv_done :
        (i_addr == adcsq_pkg::OFF_IRQ_STATUS)       ? {5'h00, irq_status} :
        (i_addr == adcsq_pkg::OFF_IRQ_MASK)         ? {5'h00, irq_mask} :
        rd_result                                   ? results[i_addr[2:0]] : 8'h00;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_value : 8'h00;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    // Counts finished conversions of the current run.
    logic [3:0] done_count;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_count <= 4'h0;
        end else if (start_req || seq_end) begin
            done_count <= 4'h0;
        end else if (done_ev) begin
            done_count <= 4'(done_count + 4'h1);
        end
    end

    property p_length;
        seq_end |-> (done_count == 4'(eight_sel ? 8 : (one_sel ? 1 : 4)) - 4'h1);
    endproperty
    a_length: assert property (p_length) else $error("wrong sequence length");

    property p_map;
        done_ev && !fifo_mode |-> res_idx == conv_idx;
    endproperty
    a_map: assert property (p_map) else $error("result not at its position");

    property p_fifo;
        done_ev && fifo_mode |=> res_idx == 3'($past(res_idx) + 3'h1);
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo index did not advance");

    property p_single_run;
        seq_end && !scan_mode |=> (state == adcsq_pkg::ST_IDLE) && seq_done;
    endproperty
    a_single_run: assert property (p_single_run) else $error("single run did not idle");

    property p_scan_run;
        seq_end && scan_mode |=> seq_done ##1 (o_conv_start || $past(start_req));
    endproperty
    a_scan_run: assert property (p_scan_run) else $error("scan did not restart");

    property p_single_chan;
        o_conv_start && !multi |-> o_conv_channel == base_code;
    endproperty
    a_single_chan: assert property (p_single_chan) else $error("wrong single channel");

    property p_multi_chan;
        o_conv_start && multi |-> o_conv_channel == 3'(base_code + conv_idx);
    endproperty
    a_multi_chan: assert property (p_multi_chan) else $error("wrong multi channel");

    property p_special;
        o_conv_start && o_conv_special |-> (o_input_select == 8'h00)
            && (o_ref_high == (o_conv_channel == adcsq_pkg::SRC_HIGH_REF));
    endproperty
    a_special: assert property (p_special) else $error("wrong internal source");

    property p_selftest;
        done_ev && o_conv_special && o_ref_high && !res10
            && (i_conv_result != adcsq_pkg::CODE_HIGH) |=> irq_status[2];
    endproperty
    a_selftest: assert property (p_selftest) else $error("self-test miss not flagged");

    property p_external;
        o_conv_start && !o_conv_special |-> o_input_select == 8'(8'h01 << o_conv_channel);
    endproperty
    a_external: assert property (p_external) else $error("wrong analog input");

    property p_readback;
        i_rd && (i_addr == adcsq_pkg::OFF_SEQUENCE_CONTROL) |=>
            o_rdata == {1'b0, $past(seq_ctl)};
    endproperty
    a_readback: assert property (p_readback) else $error("bad control readback");

    property p_restart;
        start_req |=> (state == adcsq_pkg::ST_SETUP) && !seq_done && (conv_done == 8'h00);
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear");

    property p_index_clear;
        (start_req && !fifo_mode) or (seq_end && !fifo_mode) |=> res_idx == 3'h0;
    endproperty
    a_index_clear: assert property (p_index_clear) else $error("index not cleared");

    property p_conv_flag;
        done_ev |=> conv_done[$past(res_idx)];
    endproperty
    a_conv_flag: assert property (p_conv_flag) else $error("conversion flag not set");

    c_eight_run: cover property (seq_end && eight_sel && multi);
    c_scan_run:  cover property (seq_end && scan_mode ##[1:40] seq_end);
    c_fifo_wrap: cover property (done_ev && fifo_mode && (res_idx == 3'h7));
    c_abort:     cover property ((state == adcsq_pkg::ST_CONVERT) && start_req);

endmodule

// [verification/test_adc_sequence_control.sv]
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench for the conversion-sequence controller.
// ****************************************************************
module test_adc_sequence_control;
    logic       i_sys_clk     = 1'b0;
    logic       i_reset_n     = 1'b0;
    logic [7:0] i_addr        = 8'h00;
    logic [7:0] i_wdata       = 8'h00;
    logic       i_wr          = 1'b0;
    logic       i_rd          = 1'b0;
    logic       i_conv_done   = 1'b0;
    logic [7:0] i_conv_result = 8'h00;
    logic [7:0] o_rdata, o_input_select, o_timing_control;
    logic [2:0] o_conv_channel;
    logic       o_conv_start, o_conv_abort, o_conv_special, o_ref_high, o_ref_low, o_ref_mid, o_irq;
    int         error_cnt = 0;
    int         checks    = 0;
    logic [7:0] base      = 8'h10;

    // The 200 MHz system clock.
    always #2.5 i_sys_clk = ~i_sys_clk;

    adcsq_control u_adcsq_control (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_conv_start(o_conv_start),
        .o_conv_abort(o_conv_abort), .o_conv_channel(o_conv_channel),
        .o_conv_special(o_conv_special), .o_input_select(o_input_select),
        .o_ref_high(o_ref_high), .o_ref_low(o_ref_low), .o_ref_mid(o_ref_mid),
        .o_timing_control(o_timing_control), .i_conv_done(i_conv_done),
        .i_conv_result(i_conv_result), .o_irq(o_irq));

    // ****************************************************************
    // Bus, converter and compare helpers.
    // ****************************************************************
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A gap cycle follows each strobe so back-to-back calls never re-drive it in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        cmp(what, exp, o_rdata);
        @(posedge i_sys_clk);
    endtask

    // Waits for one start, checks the selected source, then answers with a result.
    task automatic conv(input logic [2:0] ch, input logic sp, input logic [7:0] res);
        int n;
        n = 0;
        #1;
        while (o_conv_start !== 1'b1 && n < 40) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        cmp("conv_start", 8'h01, {7'h00, o_conv_start});
        cmp("conv_channel", {5'h00, ch}, {5'h00, o_conv_channel});
        cmp("conv_special", {7'h00, sp}, {7'h00, o_conv_special});
        cmp("input_select", sp ? 8'h00 : 8'h01 << ch, o_input_select);
        cmp("ref_select", {5'h00, sp && ch == 3'h4, sp && ch == 3'h5, sp && ch == 3'h6},
            {5'h00, o_ref_high, o_ref_low, o_ref_mid});
        @(posedge i_sys_clk);
        i_conv_done <= 1'b1;
        i_conv_result <= res;
        @(posedge i_sys_clk);
        i_conv_done <= 1'b0;
    endtask

    // Starts a sequence and answers every conversion; runs with fifo clear are then checked at rest.
    task automatic run_seq(input logic [7:0] ctl, input int len, input logic fifo);
        logic [7:0] flags;
        int         n;
        flags = 8'h00;
        n = 0;
        wr(adcsq_pkg::OFF_SEQUENCE_CONTROL, ctl);
        for (int k = 0; k < len; k++) begin
            conv(ctl[4] ? ctl[2:0] + 3'(k) : ctl[2:0], ctl[3], base + 8'(k * 17));
            flags[k] = 1'b1;
        end
        if (!fifo) begin
            repeat (8) begin
                @(posedge i_sys_clk);
                #1;
                if (o_conv_start === 1'b1) n++;
            end
            cmp("start_after_done", 8'h00, 8'(n));
            chk_rd("status_sequence", adcsq_pkg::OFF_STATUS_SEQUENCE, 8'h80);
            chk_rd("status_convert", adcsq_pkg::OFF_STATUS_CONVERT, flags);
            for (int k = 0; k < len; k++)
                chk_rd("result", adcsq_pkg::OFF_RESULT_BASE + 8'(k), base + 8'(k * 17));
        end
        base = base + 8'h23;
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset;
        chk_rd("sequence_control", adcsq_pkg::OFF_SEQUENCE_CONTROL, 8'h00);
        chk_rd("status_sequence", adcsq_pkg::OFF_STATUS_SEQUENCE, 8'h00);
        chk_rd("timing_control", adcsq_pkg::OFF_TIMING_CONTROL, 8'h01);
        chk_rd("unmapped", 8'h5A, 8'h00);
        cmp("irq", 8'h00, {7'h00, o_irq});
        cmp("timing_control", 8'h01, o_timing_control);
        cmp("conv_abort", 8'h00, {7'h00, o_conv_abort});
        $display("test reset finished");
    endtask

    task automatic t_lengths;
        wr(adcsq_pkg::OFF_IRQ_MASK, 8'h01);
        wr(adcsq_pkg::OFF_MISC_CONTROL, 8'h00);
        run_seq(8'h16, 4, 1'b0);
        cmp("irq", 8'h01, {7'h00, o_irq});
        chk_rd("irq_status", adcsq_pkg::OFF_IRQ_STATUS, 8'h03);
        cmp("irq", 8'h00, {7'h00, o_irq});
        run_seq(8'h05, 4, 1'b0);
        wr(adcsq_pkg::OFF_MISC_CONTROL, 8'h08);
        run_seq(8'h13, 1, 1'b0);
        run_seq(8'h52, 8, 1'b0);
        $display("test lengths finished");
    endtask

    // Correct reference codes raise only the sequence and conversion bits; a wrong one also raises the self-test bit.
    task automatic t_special;
        logic [7:0] code [4] = '{8'hFF, 8'h00, 8'h7F, 8'h55};
        wr(adcsq_pkg::OFF_IRQ_MASK, 8'h04);
        for (int k = 0; k < 4; k++) begin
            wr(adcsq_pkg::OFF_SEQUENCE_CONTROL, 8'h0C + 8'(k));
            conv(3'h4 + 3'(k), 1'b1, code[k]);
            chk_rd("irq_status", adcsq_pkg::OFF_IRQ_STATUS, 8'h03);
        end
        wr(adcsq_pkg::OFF_SEQUENCE_CONTROL, 8'h0C);
        conv(3'h4, 1'b1, 8'h12);
        repeat (2) @(posedge i_sys_clk);
        cmp("irq", 8'h01, {7'h00, o_irq});
        chk_rd("irq_status", adcsq_pkg::OFF_IRQ_STATUS, 8'h07);
        // A timing write restarts the run; at 10 bits the self-test stays quiet.
        wr(adcsq_pkg::OFF_TIMING_CONTROL, 8'h81);
        cmp("timing_control", 8'h81, o_timing_control);
        conv(3'h4, 1'b1, 8'h12);
        chk_rd("irq_status", adcsq_pkg::OFF_IRQ_STATUS, 8'h03);
        cmp("irq", 8'h00, {7'h00, o_irq});
        wr(adcsq_pkg::OFF_TIMING_CONTROL, 8'h01);
        $display("test special finished");
    endtask

    task automatic t_scan_abort;
        wr(adcsq_pkg::OFF_IRQ_MASK, 8'h00);
        wr(adcsq_pkg::OFF_SEQUENCE_CONTROL, 8'h21);
        conv(3'h1, 1'b0, 8'hA1);
        conv(3'h1, 1'b0, 8'hA2);
        chk_rd("status_sequence", adcsq_pkg::OFF_STATUS_SEQUENCE, 8'h80);
        chk_rd("status_convert", adcsq_pkg::OFF_STATUS_CONVERT, 8'h01);
        i_addr <= adcsq_pkg::OFF_SEQUENCE_CONTROL;
        i_wdata <= 8'hFF;
        i_wr <= 1'b1;
        #1;
        cmp("conv_abort", 8'h01, {7'h00, o_conv_abort});
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        @(posedge i_sys_clk);
        chk_rd("sequence_control", adcsq_pkg::OFF_SEQUENCE_CONTROL, 8'h7F);
        chk_rd("status_sequence", adcsq_pkg::OFF_STATUS_SEQUENCE, 8'h00);
        chk_rd("status_convert", adcsq_pkg::OFF_STATUS_CONVERT, 8'h00);
        $display("test scan abort finished");
    endtask

    // The index keeps running across single-conversion runs and wraps after eight.
    task automatic t_fifo;
        logic [7:0] prev;
        wr(adcsq_pkg::OFF_MISC_CONTROL, 8'h0C);
        for (int k = 0; k < 9; k++) begin
            prev = base;
            run_seq(8'h02, 1, 1'b1);
            repeat (2) @(posedge i_sys_clk);
            chk_rd("status_sequence", adcsq_pkg::OFF_STATUS_SEQUENCE, 8'h80 | 8'((k + 1) % 8));
            chk_rd("result", adcsq_pkg::OFF_RESULT_BASE + 8'(k % 8), prev);
        end
        $display("test fifo finished");
    endtask

    task automatic print_verdict;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(posedge i_sys_clk);
        t_reset();
        t_lengths();
        t_special();
        t_scan_abort();
        t_fifo();
        print_verdict();
    end

    // The whole run needs a few hundred cycles; twenty thousand means a hang.
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule
